// *** verilog/dps_pkg.sv ***
// dps_pkg: constants, commands and carriers for the debug port security lock.
// assumes: included first; shared by the lock controller and the majority matcher.
package dps_pkg;

  // latch geometry and majority threshold
  localparam int KEY_W     = 32;
  localparam int MATCH_MIN = 28;
  localparam int CNT_W     = 6;

  // flash block addressing and protection levels
  localparam int BLK_W = 4;
  localparam int PROT_W = 2;
  localparam logic [PROT_W-1:0] PROT_NONE  = 2'h0;  // erase, program, verify allowed
  localparam logic [PROT_W-1:0] PROT_WRITE = 2'h1;  // verify only
  localparam logic [PROT_W-1:0] PROT_FULL  = 2'h2;  // no block erase, program or verify

  // which debug port carried the request
  typedef enum logic {
    PORT_JTAG,
    PORT_SWD
  } dps_port_t;

  // debug port commands
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_READ_LATCH,
    CMD_LOAD_KEY,
    CMD_COMMIT_KEY,
    CMD_ERASE_LATCH,
    CMD_SET_PROT,
    CMD_DEV_ERASE,
    CMD_DEV_PROG,
    CMD_DEV_VERIFY,
    CMD_BLK_ERASE,
    CMD_BLK_PROG,
    CMD_BLK_VERIFY,
    CMD_ENTER_DEBUG,
    CMD_ENTER_TEST,
    CMD_MEM_READ
  } dps_cmd_t;

  // request from the debug port front end
  typedef struct packed {
    logic             valid;
    dps_port_t        port;
    dps_cmd_t         cmd;
    logic [BLK_W-1:0] blk;
    logic [KEY_W-1:0] data;
  } dps_req_t;

  // answer to the debug port front end
  typedef struct packed {
    logic             ack;
    logic             refused;
    logic [KEY_W-1:0] rdata;
  } dps_resp_t;

  // operation handed to the flash controller
  typedef struct packed {
    logic             valid;
    dps_cmd_t         op;
    logic [BLK_W-1:0] blk;
    logic [KEY_W-1:0] data;
  } dps_flash_t;

  // program or erase order for the nonvolatile latch cells
  typedef struct packed {
    logic             valid;
    logic             erase;
    logic [KEY_W-1:0] data;
  } dps_nvl_t;

endpackage : dps_pkg

// *** verilog/dps_match.sv ***
// dps_match: super-majority comparison of the nonvolatile latch cells against the key.
// assumes: cells come straight from the latch macro and are stable around reset release.
`timescale 1ns/100ps
`default_nettype none
module dps_match #(
  parameter logic [31:0] KEY_PATTERN = 32'hA5C3_0F96,  // value is arbitrary
  parameter int          MIN_EQUAL   = 28
) (
  input  wire logic [31:0] cells,
  output logic             match
);
  import dps_pkg::*;

  // elaboration check: the threshold must be reachable by a 32-bit word
  if (MIN_EQUAL < 1 || MIN_EQUAL > KEY_W) begin : gen_min_chk
    $error("dps_match: MIN_EQUAL out of range");
  end

  // count of ones in a word
  function automatic logic [CNT_W-1:0] ones(input logic [KEY_W-1:0] w);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < KEY_W; i++) begin
      n = n + CNT_W'(w[i]);
    end
    return n;
  endfunction : ones

  // a few dead cells must not drop the lock, so full equality is not required
  always_comb begin
    match = (ones(~(cells ^ KEY_PATTERN)) >= CNT_W'(MIN_EQUAL));  // R3 R2
  end

endmodule : dps_match
`default_nettype wire

// *** verilog/dps_lock.sv ***
// dps_lock: security lock that gates the test, programming and debug ports.
// assumes: one request per cycle from the port front end, latch cells from an
// external macro, flash controller takes one-cycle operation pulses.
// Function
// R1: active lock permanently disables all debug ports
// R2: latch holds a 32-bit value for comparison
// R3: lock when 28 of 32 bits match key
// R4: locked: refuse debug/test entry, latch changes
// R5: lock needs load, commit, then reset
// R6: lock output sampled only at reset
// R7: key write only without any flash protection
// R8: access stays open after commit until reset
// R9: latch readable over serial wire debug port
// R10: protection raised freely, cleared only by erase (sys_rst also clears every level)
// R11: block operations obey that block's protection
// R12: whole-device erase/program/verify when unlocked
// R13: locked requests get no data (SWD latch read still returns the cells); mismatch unlocks
`timescale 1ns/100ps
`default_nettype none
module dps_lock
  import dps_pkg::*;
#(
  parameter logic [31:0] KEY_PATTERN = 32'hA5C3_0F96,  // value is arbitrary
  parameter int          NUM_BLOCKS  = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire dps_pkg::dps_req_t req,
  input  wire logic [31:0]       nvl_cells,
  input  wire logic [31:0]       mem_rdata,
  output dps_pkg::dps_resp_t     resp,
  output dps_pkg::dps_flash_t    flash_op,
  output dps_pkg::dps_nvl_t      nvl_op,
  output logic                   jtag_en,
  output logic                   swd_en,
  output logic                   test_en,
  output logic                   debug_mode,
  output logic                   test_mode,
  output logic                   lock_active,
  output logic [NUM_BLOCKS-1:0][1:0] prot_level
);
  import dps_pkg::*;

  // smallest index width that reaches every implemented block
  localparam int IDX_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

  // elaboration check: the request block field must reach every block
  if (NUM_BLOCKS < 1 || NUM_BLOCKS > (1 << BLK_W)) begin : gen_blk_chk
    $error("dps_lock: NUM_BLOCKS out of range");
  end

  typedef struct packed {
    logic                              sampled;
    logic                              locked;
    logic [KEY_W-1:0]                  vol_key;
    logic [NUM_BLOCKS-1:0][PROT_W-1:0] prot;
    logic                              dbg;
    logic                              tst;
    dps_resp_t                         resp;
    dps_flash_t                        flash;
    dps_nvl_t                          nonvolatile_latch;
  } dps_state_t;

  dps_state_t st_ff;
  dps_state_t nxt_st;
  logic       latch_match;
  logic       gate;
  logic       ok;
  logic       prot_any;
  logic [PROT_W-1:0] lvl;

  dps_match #(
    .KEY_PATTERN (KEY_PATTERN),
    .MIN_EQUAL   (MATCH_MIN)
  ) u_match (
    .cells (nvl_cells),
    .match (latch_match)
  );

  // block index within the implemented range
  function automatic logic blk_ok(input logic [BLK_W-1:0] b);
    return (32'(b) < NUM_BLOCKS);
  endfunction : blk_ok

  // ports open only once the lock has been sampled and found clear
  assign gate     = st_ff.sampled & ~st_ff.locked;  // R1 R8
  assign prot_any = |st_ff.prot;
  assign lvl      = blk_ok(req.blk) ? st_ff.prot[req.blk[IDX_W-1:0]] : PROT_FULL;

  // next state: sampling, command decode and one-cycle pulses
  always_comb begin
    nxt_st = st_ff;
    nxt_st.resp  = '0;
    nxt_st.flash = '0;
    nxt_st.nonvolatile_latch   = '0;
    ok = 1'b0;
    // first enabled edge after reset release takes the latch verdict, then never again
    if (!st_ff.sampled) begin
      nxt_st.sampled = 1'b1;  // R6
      nxt_st.locked  = latch_match;  // R5 R13
    end
    if (req.valid) begin
      case (req.cmd)
        CMD_READ_LATCH: ok = st_ff.sampled && (req.port == PORT_SWD);  // R9
        CMD_LOAD_KEY: begin
          ok = gate && !prot_any;  // R7 R4
          if (ok) nxt_st.vol_key = req.data;
        end
        CMD_COMMIT_KEY: begin
          ok = gate && !prot_any;  // R7 R4
          nxt_st.nonvolatile_latch.valid = ok;  // R5
          nxt_st.nonvolatile_latch.data  = st_ff.vol_key;
        end
        CMD_ERASE_LATCH: begin
          ok = gate;  // R4
          nxt_st.nonvolatile_latch.valid = ok;
          nxt_st.nonvolatile_latch.erase = ok;
        end
        CMD_SET_PROT: begin
          // levels only go up here; a lower value is refused
          ok = gate && blk_ok(req.blk) && (req.data[PROT_W-1:0] >= lvl);  // R10
          if (ok) nxt_st.prot[req.blk[IDX_W-1:0]] = req.data[PROT_W-1:0];
        end
        CMD_DEV_ERASE: begin
          ok = gate;  // R12
          if (ok) nxt_st.prot = '0;  // R10
        end
        CMD_DEV_PROG,
        CMD_DEV_VERIFY: ok = gate;  // R12
        CMD_BLK_ERASE,
        CMD_BLK_PROG: ok = gate && (lvl == PROT_NONE);  // R11
        CMD_BLK_VERIFY: ok = gate && (lvl != PROT_FULL);  // R11
        CMD_ENTER_DEBUG: begin
          ok = gate;  // R4
          if (ok) nxt_st.dbg = 1'b1;
        end
        CMD_ENTER_TEST: begin
          ok = gate;  // R4
          if (ok) nxt_st.tst = 1'b1;
        end
        CMD_MEM_READ: ok = gate;
        default: ok = 1'b0;
      endcase
      nxt_st.resp.ack     = 1'b1;
      nxt_st.resp.refused = ~ok;  // R13
      if (ok && req.cmd == CMD_READ_LATCH) begin
        nxt_st.resp.rdata = nvl_cells;  // R9
      end else if (ok && req.cmd == CMD_MEM_READ) begin
        nxt_st.resp.rdata = mem_rdata;
      end
      if (ok && req.cmd >= CMD_DEV_ERASE && req.cmd <= CMD_BLK_VERIFY) begin
        nxt_st.flash.valid = 1'b1;  // R11 R12
        nxt_st.flash.op    = req.cmd;
        nxt_st.flash.blk   = req.blk;
        nxt_st.flash.data  = req.data;
      end
    end
  end

  // single state register; clk_en low freezes everything
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign resp        = st_ff.resp;
  assign flash_op    = st_ff.flash;
  assign nvl_op      = st_ff.nonvolatile_latch;
  assign jtag_en     = gate;  // R1
  assign swd_en      = gate;  // R1
  assign test_en     = gate;  // R1
  assign debug_mode  = st_ff.dbg;
  assign test_mode   = st_ff.tst;
  assign lock_active = st_ff.locked;
  assign prot_level  = st_ff.prot;

  // helper terms for the checks below
  logic take;
  assign take      = clk_en && req.valid;

  // true when any block's level sits below its previous value
  function automatic logic prot_fell(input logic [NUM_BLOCKS-1:0][PROT_W-1:0] cur,
                                     input logic [NUM_BLOCKS-1:0][PROT_W-1:0] prev);
    logic f;
    f = 1'b0;
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      f = f | (cur[i] < prev[i]);
    end
    return f;
  endfunction : prot_fell

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence guarded_req_s;
    take && st_ff.locked && (req.cmd inside {CMD_ENTER_DEBUG, CMD_ENTER_TEST, CMD_LOAD_KEY, CMD_COMMIT_KEY});
  endsequence
  sequence refused_s;
    resp.ack && resp.refused && !nvl_op.valid;
  endsequence

  ports_closed_a: assert property (st_ff.locked |-> !jtag_en && !swd_en && !test_en)  // R1
    else $error("ports open while locked");
  lock_sample_a: assert property ($rose(st_ff.sampled) |-> st_ff.locked == $past(latch_match))  // R6 R3
    else $error("lock not taken from matcher");
  lock_hold_a: assert property (st_ff.sampled |=> $stable(st_ff.locked) && st_ff.sampled)  // R6 R8
    else $error("lock changed without reset");
  locked_refuse_a: assert property (guarded_req_s |=> refused_s)  // R4
    else $error("locked request not refused");
  commit_prog_a: assert property (take && gate && !prot_any && req.cmd == CMD_COMMIT_KEY  // R5 R8
      |=> nvl_op.valid && nvl_op.data == $past(st_ff.vol_key) && !st_ff.locked)
    else $error("commit did not program latch");
  key_refused_a: assert property (take && prot_any && req.cmd == CMD_LOAD_KEY  // R7
      |=> resp.refused && st_ff.vol_key == $past(st_ff.vol_key))
    else $error("key write accepted under protection");
  swd_read_a: assert property (take && st_ff.sampled && req.cmd == CMD_READ_LATCH && req.port == PORT_SWD  // R9
      |=> resp.ack && !resp.refused && resp.rdata == $past(nvl_cells))
    else $error("latch read over swd failed");
  prot_clear_a: assert property ($past(clk_en) && prot_fell(st_ff.prot, $past(st_ff.prot))  // R10
      |-> $past(req.valid && req.cmd == CMD_DEV_ERASE) && st_ff.prot == '0)
    else $error("protection lowered without erase");
  block_guard_a: assert property (take && req.cmd == CMD_BLK_ERASE && lvl != PROT_NONE  // R11
      |=> resp.refused && !flash_op.valid)
    else $error("protected block erased");
  dev_erase_a: assert property (take && gate && req.cmd == CMD_DEV_ERASE  // R12
      |=> flash_op.valid && flash_op.op == CMD_DEV_ERASE && st_ff.prot == '0)
    else $error("device erase not issued");
  locked_nodata_a: assert property (take && st_ff.locked && req.cmd == CMD_MEM_READ  // R13
      |=> resp.rdata == '0 ##1 !debug_mode)
    else $error("locked part returned data");

endmodule : dps_lock
`default_nettype wire

// *** verif/dps_dbg.sv ***
// dps_dbg: debugger model on the request side of the lock.
// assumes: lock is always ready and answers one enabled edge after a request.
`timescale 1ns/100ps
`default_nettype none
module dps_dbg (
  input  wire logic               clk_sys,
  output dps_pkg::dps_req_t       req,
  input  wire dps_pkg::dps_resp_t resp
);
  import dps_pkg::*;
  initial req = '0;
  // one request per call; released data lines carry the inverse so stale data never looks valid
  task automatic xfer(input dps_port_t p, input dps_cmd_t c, input logic [BLK_W-1:0] b,
                      input logic [KEY_W-1:0] d, output dps_resp_t r);
    @(posedge clk_sys);
    req <= '{1'h1, p, c, b, d};
    @(posedge clk_sys);
    req <= '{1'h0, p, CMD_NOP, b, ~d};
    #1 r = resp;
  endtask : xfer
endmodule : dps_dbg
`default_nettype wire

// *** verif/testbench.sv ***
// testbench: directed scenarios for the debug port security lock.
// assumes: dps_dbg drives requests; a small latch model stands in for the cells.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dps_pkg::*;
  localparam logic [31:0] KEY = 32'h3C5A_96E1;  // value is arbitrary
  localparam logic [31:0] MEM = 32'h0F1E_2D3C;
  logic            clk_sys   = 1'h0;
  logic            sys_rst   = 1'h1;
  logic            clk_en    = 1'h1;
  logic [31:0]     nvl_cells = 32'h0;
  logic [31:0]     mem_rdata = MEM;
  dps_req_t        req;
  dps_resp_t       resp;
  dps_resp_t       r;
  dps_flash_t      flash_op;
  dps_nvl_t        nvl_op;
  logic            jtag_en, swd_en, test_en, debug_mode, test_mode, lock_active;
  logic [3:0][1:0] prot_level;
  int              fails     = 0;
  int              cmp_count = 0;
  int              cyc       = 0;

  always #12.5 clk_sys = ~clk_sys;

  dps_lock #(.KEY_PATTERN(KEY), .NUM_BLOCKS(4)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(clk_en), .req(req), .nvl_cells(nvl_cells), .mem_rdata(mem_rdata), .resp(resp),
    .flash_op(flash_op), .nvl_op(nvl_op), .jtag_en(jtag_en), .swd_en(swd_en), .test_en(test_en),
    .debug_mode(debug_mode), .test_mode(test_mode), .lock_active(lock_active),
    .prot_level(prot_level));
  dps_dbg u_dbg (.clk_sys(clk_sys), .req(req), .resp(resp));

  // latch macro: a commit writes the cells, an erase clears them
  always @(posedge clk_sys) begin
    if (nvl_op.valid) nvl_cells <= nvl_op.erase ? 32'h0 : nvl_op.data;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic send(input dps_port_t p, input dps_cmd_t c, input logic [3:0] b,
                      input logic [31:0] d, input logic rf);
    u_dbg.xfer(p, c, b, d, r);
    chk("answer", {r.ack, r.refused}, {1'h1, rf});
  endtask : send

  // reset held 20 cycles, raised and released on rising edges with the given cells
  task automatic do_reset(input logic [31:0] c);
    @(posedge clk_sys);
    sys_rst   <= 1'h1;
    nvl_cells <= c;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
  endtask : do_reset

  task automatic t_boot();
    fork
      do_reset(32'h0);
      begin
        repeat (20) @(posedge clk_sys);
        send(PORT_JTAG, CMD_DEV_ERASE, 4'h0, 32'h0, 1'h1);
      end
    join
    chk("flash early", flash_op.valid, 1'h0);
    chk("ports", {lock_active, jtag_en, swd_en, test_en}, 4'h7);
    for (int i = CMD_DEV_ERASE; i <= CMD_DEV_VERIFY; i++) begin
      send(dps_port_t'(i[0]), dps_cmd_t'(i), 4'h0, 32'h0, 1'h0);
      chk("flash op", {flash_op.valid, flash_op.op}, {1'h1, 4'(i)});
    end
    send(PORT_SWD, CMD_ENTER_DEBUG, 4'h0, 32'h0, 1'h0);
    chk("debug mode", debug_mode, 1'h1);
    // clk_en low: the request is not taken and nothing moves
    @(posedge clk_sys) clk_en <= 1'h0;
    u_dbg.xfer(PORT_SWD, CMD_ENTER_TEST, 4'h0, 32'h0, r);
    chk("frozen", {r.ack, test_mode}, 2'h0);
    @(posedge clk_sys) clk_en <= 1'h1;
    send(PORT_SWD, CMD_ENTER_TEST, 4'h0, 32'h0, 1'h0);
    chk("test mode", test_mode, 1'h1);
  endtask : t_boot

  task automatic t_prot();
    send(PORT_JTAG, CMD_SET_PROT, 4'h1, 32'h1, 1'h0);
    send(PORT_JTAG, CMD_SET_PROT, 4'h1, 32'h0, 1'h1);
    chk("level", prot_level[1], 2'h1);
    send(PORT_SWD, CMD_BLK_ERASE, 4'h1, 32'h0, 1'h1);
    send(PORT_SWD, CMD_BLK_VERIFY, 4'h1, 32'h0, 1'h0);
    chk("blk verify", {flash_op.valid, flash_op.blk}, 5'h11);
    send(PORT_SWD, CMD_BLK_PROG, 4'h0, 32'h0, 1'h0);
    send(PORT_SWD, CMD_LOAD_KEY, 4'h0, KEY, 1'h1);
    send(PORT_JTAG, CMD_DEV_ERASE, 4'h0, 32'h0, 1'h0);
    chk("level erased", prot_level[1], 2'h0);
  endtask : t_prot

  task automatic t_lock();
    do_reset(32'h0);
    send(PORT_SWD, CMD_LOAD_KEY, 4'h0, KEY, 1'h0);
    send(PORT_SWD, CMD_COMMIT_KEY, 4'h0, 32'h0, 1'h0);
    chk("commit", {nvl_op.valid, nvl_op.erase}, 2'h2);
    chk("commit data", nvl_op.data, KEY);
    send(PORT_JTAG, CMD_MEM_READ, 4'h0, 32'h0, 1'h0);
    chk("open read", r.rdata, MEM);
    chk("still open", {lock_active, jtag_en}, 2'h1);
    do_reset(KEY);
    send(PORT_SWD, CMD_READ_LATCH, 4'h0, 32'h0, 1'h0);
    chk("latch id", r.rdata, KEY);
    chk("locked", {lock_active, jtag_en, swd_en, test_en}, 4'h8);
    send(PORT_JTAG, CMD_ENTER_DEBUG, 4'h0, 32'h0, 1'h1);
    send(PORT_SWD, CMD_ERASE_LATCH, 4'h0, 32'h0, 1'h1);
    chk("no erase", nvl_op.valid, 1'h0);
    send(PORT_SWD, CMD_MEM_READ, 4'h0, 32'h0, 1'h1);
    chk("no data", r.rdata, 32'h0);
    chk("modes", {debug_mode, test_mode}, 2'h0);
  endtask : t_lock

  task automatic t_major();
    do_reset(KEY ^ 32'h1010_1010);
    send(PORT_SWD, CMD_NOP, 4'h0, 32'h0, 1'h1);
    chk("four off", lock_active, 1'h1);
    do_reset(KEY ^ 32'h1010_1011);
    send(PORT_SWD, CMD_READ_LATCH, 4'h0, 32'h0, 1'h0);
    chk("five off", {lock_active, jtag_en}, 2'h1);
    send(PORT_JTAG, CMD_READ_LATCH, 4'h0, 32'h0, 1'h1);
    chk("jtag latch", r.rdata, 32'h0);
    send(PORT_JTAG, CMD_ERASE_LATCH, 4'h0, 32'h0, 1'h0);
    chk("latch erase", {nvl_op.valid, nvl_op.erase}, 2'h3);
  endtask : t_major

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial begin
    t_boot();
    t_prot();
    t_lock();
    t_major();
    final_report();
  end
endmodule : testbench
`default_nettype wire
